/* File: eeprom_pkg.sv */
package eeprom_pkg;

	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W    = 11;
	localparam int DATA_W    = 8;
	localparam int BLOCK_W   = 3;
	localparam int PAGE_W    = 4;
	localparam int PAGE_SIZE = 16;

	// ----------------------------------------------------------------
	// device address word fields
	// ----------------------------------------------------------------
	localparam logic [3:0] DEV_PATTERN = 4'hA;
	localparam int         PATTERN_LSB = 4;
	localparam int         BLOCK_LSB   = 1;
	localparam int         RW_BIT      = 0;

	// ----------------------------------------------------------------
	// bit counter values within a nine-clock byte slot
	// ----------------------------------------------------------------
	localparam logic [3:0] FIRST_BIT = 4'h0;
	localparam logic [3:0] LAST_BIT  = 4'h7;
	localparam logic [3:0] ACK_BIT   = 4'h8;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ                 = 40_000_000;
	localparam int INTERNAL_WRITE_TIME_MS = 5;
	localparam int WRITE_CYCLES_DEF       =
		INTERNAL_WRITE_TIME_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		L_IDLE,
		L_DEV_ADDR,
		L_WORD_ADDR,
		L_WRITE_DATA,
		L_READ_DATA
	} link_state_e;

	typedef enum logic [1:0] {
		C_IDLE,
		C_COPY,
		C_WAIT
	} commit_state_e;

endpackage

/* File: bit_sync.sv */
`timescale 1ns/1ps

module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		meta_reg <= d;
		q        <= meta_reg;
	end

endmodule

/* File: eeprom_mem.sv */
`timescale 1ns/1ps

module eeprom_mem #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	input  wire logic          wclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          rclk,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge wclk) begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge rclk) begin
		rdata <= mem[raddr];
	end

endmodule

/* File: eeprom_target.sv */
`timescale 1ns/1ps

module eeprom_target import eeprom_pkg::*; #(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic wp,
	output logic      write_busy
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                start_tog_reg;
	logic                stop_tog_reg;
	logic                start_cp_reg;
	logic                stop_cp_reg;
	link_state_e         state_reg;
	logic [3:0]          bit_cnt_reg;
	logic [DATA_W-1:0]   rx_reg;
	logic [DATA_W-1:0]   tx_reg;
	logic                mack_reg;
	logic                oe_reg;
	logic                armed_reg;
	logic                rw_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic [PAGE_SIZE-1:0] mask_reg;
	logic [DATA_W-1:0]   mem_q;
	logic [DATA_W-1:0]   buf_q;
	logic                link_rst;
	logic                busy_s;
	logic                stop_s;
	logic                stop_d_reg;
	logic                armed_s;
	logic                wp_s;
	commit_state_e       cstate_reg;
	logic [PAGE_W:0]     idx_reg;
	logic [PAGE_W-1:0]   idx_d_reg;
	logic [31:0]         wait_cnt_reg;

	wire start_seen = start_tog_reg ^ start_cp_reg;
	wire stop_seen  = stop_tog_reg ^ stop_cp_reg;
	wire link_event = start_seen | stop_seen;
	wire at_last    = (bit_cnt_reg == LAST_BIT);
	wire at_ack     = (bit_cnt_reg == ACK_BIT);
	wire dev_match  = (rx_reg[DATA_W-1:PATTERN_LSB] == DEV_PATTERN) &&
		!busy_s;
	wire [ADDR_W-1:0] addr_inc  = addr_reg + 1'b1;
	wire [ADDR_W-1:0] addr_page = {addr_reg[ADDR_W-1:PAGE_W],
		addr_reg[PAGE_W-1:0] + 1'b1};
	wire buf_we     = (state_reg == L_WRITE_DATA) && at_ack;
	wire stop_ev    = stop_s ^ stop_d_reg;
	wire commit_go  = stop_ev && armed_s && !wp_s && (cstate_reg == C_IDLE);
	wire copy_last  = (idx_reg == (PAGE_W + 1)'(PAGE_SIZE));
	wire mem_we     = (cstate_reg == C_COPY) && (idx_reg != '0) &&
		mask_reg[idx_d_reg];
	wire wait_done  = (wait_cnt_reg == 32'(WRITE_CYCLES - 1));

	assign sda_out    = 1'b0;
	assign sda_oe     = oe_reg;
	assign write_busy = (cstate_reg != C_IDLE);

	// ----------------------------------------------------------------
	// crossings
	// ----------------------------------------------------------------
	bit_sync #(.W(2)) u_to_link (
		.clk (scl),
		.d   ({srst, write_busy}),
		.q   ({link_rst, busy_s})
	);

	bit_sync #(.W(3)) u_to_core (
		.clk (clk),
		.d   ({stop_tog_reg, armed_reg, wp}),
		.q   ({stop_s, armed_s, wp_s})
	);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	eeprom_mem #(.AW(ADDR_W), .DW(DATA_W)) u_array (
		.wclk  (clk),
		.we    (mem_we),
		.waddr ({addr_reg[ADDR_W-1:PAGE_W], idx_d_reg}),
		.wdata (buf_q),
		.rclk  (scl),
		.raddr (addr_reg),
		.rdata (mem_q)
	);

	eeprom_mem #(.AW(PAGE_W), .DW(DATA_W)) u_page_buf (
		.wclk  (scl),
		.we    (buf_we),
		.waddr (addr_reg[PAGE_W-1:0]),
		.wdata (rx_reg),
		.rclk  (clk),
		.raddr (idx_reg[PAGE_W-1:0]),
		.rdata (buf_q)
	);

	// ----------------------------------------------------------------
	// start and stop detectors
	// ----------------------------------------------------------------
	always_ff @(negedge sda_in or posedge srst) begin
		if (srst)
			start_tog_reg <= 1'b0;
		else if (scl)
			start_tog_reg <= ~start_tog_reg;
	end

	always_ff @(posedge sda_in or posedge srst) begin
		if (srst)
			stop_tog_reg <= 1'b0;
		else if (scl)
			stop_tog_reg <= ~stop_tog_reg;
	end

	// ----------------------------------------------------------------
	// link: rising edge samples
	// ----------------------------------------------------------------
	always_ff @(posedge scl) begin
		if (state_reg != L_IDLE && !at_ack)
			rx_reg <= {rx_reg[DATA_W-2:0], sda_in};
		if (at_ack)
			mack_reg <= sda_in;
	end

	// ----------------------------------------------------------------
	// link: falling edge protocol
	// ----------------------------------------------------------------
	always_ff @(negedge scl or posedge srst) begin
		if (srst)
			oe_reg <= 1'b0;
		else if (link_rst || link_event)
			oe_reg <= 1'b0;
		else if (state_reg == L_IDLE)
			oe_reg <= 1'b0;
		else if (at_last)
			oe_reg <= (state_reg != L_READ_DATA) &&
				((state_reg != L_DEV_ADDR) || dev_match);
		else if (at_ack)
			oe_reg <= ((state_reg == L_DEV_ADDR && rw_reg) ||
				(state_reg == L_READ_DATA && !mack_reg)) &&
				!mem_q[DATA_W-1];
		else
			oe_reg <= (state_reg == L_READ_DATA) && !tx_reg[DATA_W-2];
	end

	always_ff @(negedge scl) begin
		if (link_rst) begin
			state_reg    <= L_IDLE;
			bit_cnt_reg  <= FIRST_BIT;
			armed_reg    <= 1'b0;
			start_cp_reg <= start_tog_reg;
			stop_cp_reg  <= stop_tog_reg;
		end else if (start_seen) begin
			state_reg    <= L_DEV_ADDR;
			bit_cnt_reg  <= FIRST_BIT;
			armed_reg    <= 1'b0;
			start_cp_reg <= start_tog_reg;
			stop_cp_reg  <= stop_tog_reg;
		end else if (stop_seen) begin
			state_reg    <= L_IDLE;
			stop_cp_reg  <= stop_tog_reg;
		end else if (state_reg != L_IDLE) begin
			if (at_last) begin
				bit_cnt_reg <= ACK_BIT;
				unique case (state_reg)
					L_DEV_ADDR: begin
						if (dev_match) begin
							rw_reg <= rx_reg[RW_BIT];
							addr_reg[ADDR_W-1:ADDR_W-BLOCK_W] <=
								rx_reg[BLOCK_LSB+:BLOCK_W];
						end else
							state_reg <= L_IDLE;
					end
					L_WORD_ADDR:
						addr_reg[ADDR_W-BLOCK_W-1:0] <= rx_reg;
					L_WRITE_DATA,
					L_READ_DATA: begin
					end
				endcase
			end else if (at_ack) begin
				bit_cnt_reg <= FIRST_BIT;
				unique case (state_reg)
					L_DEV_ADDR: begin
						if (rw_reg) begin
							state_reg <= L_READ_DATA;
							tx_reg    <= mem_q;
							addr_reg  <= addr_inc;
						end else
							state_reg <= L_WORD_ADDR;
					end
					L_WORD_ADDR: begin
						state_reg <= L_WRITE_DATA;
						mask_reg  <= '0;
					end
					L_WRITE_DATA: begin
						mask_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
						addr_reg  <= addr_page;
						armed_reg <= 1'b1;
					end
					L_READ_DATA: begin
						if (!mack_reg) begin
							tx_reg   <= mem_q;
							addr_reg <= addr_inc;
						end else
							state_reg <= L_IDLE;
					end
					default: state_reg <= L_IDLE;
				endcase
			end else begin
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
				tx_reg      <= {tx_reg[DATA_W-2:0], 1'b0};
				if (state_reg == L_WRITE_DATA)
					armed_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// core: self-timed write cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cstate_reg   <= C_IDLE;
			stop_d_reg   <= 1'b0;
			idx_reg      <= '0;
			idx_d_reg    <= '0;
			wait_cnt_reg <= '0;
		end else begin
			stop_d_reg <= stop_s;
			unique case (cstate_reg)
				C_IDLE: begin
					idx_reg <= '0;
					if (commit_go)
						cstate_reg <= C_COPY;
				end
				C_COPY: begin
					idx_reg   <= idx_reg + 1'b1;
					idx_d_reg <= idx_reg[PAGE_W-1:0];
					if (copy_last) begin
						cstate_reg   <= C_WAIT;
						wait_cnt_reg <= '0;
					end
				end
				C_WAIT: begin
					wait_cnt_reg <= wait_cnt_reg + 1'b1;
					if (wait_done)
						cstate_reg <= C_IDLE;
				end
				default: cstate_reg <= C_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	commit_start_a: assert property (@(posedge clk) disable iff (srst)
		commit_go |=> (cstate_reg == C_COPY) ##17 (cstate_reg == C_WAIT))
		else $error("write cycle did not start and copy");

	protect_block_a: assert property (@(posedge clk) disable iff (srst)
		(stop_ev && wp_s && cstate_reg == C_IDLE) |=>
			(cstate_reg == C_IDLE)[*2])
		else $error("protected write started a cycle");

	unarmed_stop_a: assert property (@(posedge clk) disable iff (srst)
		(stop_ev && !armed_s && cstate_reg == C_IDLE) |=>
			cstate_reg == C_IDLE)
		else $error("write cycle without acked byte");

	array_write_a: assert property (@(posedge clk) disable iff (srst)
		mem_we |-> (cstate_reg == C_COPY) && !$past(wp_s, 17))
		else $error("array written outside copy");

	wait_bound_a: assert property (@(posedge clk) disable iff (srst)
		(cstate_reg == C_WAIT && !wait_done) |=>
			(cstate_reg == C_WAIT) &&
			(wait_cnt_reg == $past(wait_cnt_reg) + 1'b1))
		else $error("write cycle ended early");

	busy_nack_a: assert property (@(negedge scl) disable iff (link_rst)
		(state_reg == L_DEV_ADDR && at_last && busy_s && !link_event) |=>
			(!oe_reg && state_reg == L_IDLE))
		else $error("acked during write cycle");

	match_ack_a: assert property (@(negedge scl) disable iff (link_rst)
		(state_reg == L_DEV_ADDR && at_last && dev_match && !link_event)
			|=> oe_reg && at_ack)
		else $error("matching address not acked");

	start_reset_a: assert property (@(negedge scl) disable iff (link_rst)
		start_seen |=> (state_reg == L_DEV_ADDR && bit_cnt_reg == FIRST_BIT
			&& !oe_reg))
		else $error("start did not restart framing");

	page_wrap_a: assert property (@(negedge scl) disable iff (link_rst)
		(state_reg == L_WRITE_DATA && at_ack && !link_event) |=>
			addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W]))
		else $error("page bits moved during page write");

	read_step_a: assert property (@(negedge scl) disable iff (link_rst)
		(state_reg == L_READ_DATA && at_ack && !mack_reg && !link_event)
			|=> addr_reg == ADDR_W'($past(addr_reg) + 1'b1))
		else $error("read counter did not advance");

	write_cycle_c: cover property (@(posedge clk) disable iff (srst)
		commit_go);

	seq_read_c: cover property (@(negedge scl) disable iff (link_rst)
		(state_reg == L_READ_DATA && at_ack && !mack_reg));

	nack_busy_c: cover property (@(negedge scl) disable iff (link_rst)
		(state_reg == L_DEV_ADDR && at_last && busy_s));

endmodule

/* File: bus_ctl_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-wire bus controller, scl period 6 ns
// ----------------------------------------------------------------
module bus_ctl_model (
	output logic       scl,
	output logic       ctl_oe,
	input  wire logic  sda,
	output logic [8:0] res,
	output logic       res_evt
);

	initial begin
		scl = 1'b1;
		ctl_oe = 1'b0;
		res = '0;
		res_evt = 1'b0;
	end

	// start or repeated start; scl left low
	task automatic start();
		#1 ctl_oe = 1'b0;
		#2 scl = 1'b1;
		#3 ctl_oe = 1'b1;
		#3 scl = 1'b0;
	endtask

	// entered with scl low
	task automatic stop();
		#1 ctl_oe = 1'b1;
		#2 scl = 1'b1;
		#3 ctl_oe = 1'b0;
		#3;
	endtask

	// clocks with sda released
	task automatic pulses(input int n);
		#1 ctl_oe = 1'b0;
		repeat (n) begin
			#2 scl = 1'b1;
			#3 scl = 1'b0;
			#1;
		end
	endtask

	// nine bit slots, msb first; sda sampled as scl rises
	task automatic xfer(input logic [8:0] w);
		for (int i = 8; i >= 0; i--) begin
			#1 ctl_oe = ~w[i];
			#2 scl = 1'b1;
			res[i] = sda;
			#3 scl = 1'b0;
		end
		res_evt = ~res_evt;
	endtask

endmodule

/* File: two_wire_serial_eeprom_target_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin \
	comparisons++; \
	if ((a) !== (e)) begin \
		miscompares++; \
		$display("ERROR %0t: got %h expected %h", $time, a, e); \
	end \
end

module two_wire_serial_eeprom_target_tb import eeprom_pkg::*; ();
	localparam int WCYC = 40;

	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       wp = 1'b0;
	logic       scl;
	logic       ctl_oe;
	logic       sda_out;
	logic       sda_oe;
	logic       write_busy;
	logic       res_evt;
	logic [8:0] res;
	logic [8:0] exp_v;
	logic [7:0] mem [0:2047];
	logic [8:0] exp_q [$];
	int         seed = 32'h49A0;
	int         comparisons = 0;
	int         miscompares = 0;
	wire        sda = (sda_oe | ctl_oe) ? 1'b0 : 1'b1;

	always #12.5 clk = ~clk;

	eeprom_target #(.WRITE_CYCLES(WCYC)) dut (
		.clk(clk), .srst(srst), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .wp(wp),
		.write_busy(write_busy));

	bus_ctl_model ctl (
		.scl(scl), .ctl_oe(ctl_oe), .sda(sda), .res(res),
		.res_evt(res_evt));

	// ----------------------------------------------------------------
	// result checker
	// ----------------------------------------------------------------
	always @(res_evt) begin
		if (!srst) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("ERROR %0t: unexpected result", $time);
			end else begin
				exp_v = exp_q.pop_front();
				`CHK(res, exp_v)
			end
		end
	end

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic xf(input logic [8:0] w, input logic [8:0] e);
		exp_q.push_back(e);
		ctl.xfer(w);
	endtask

	task automatic wb(input logic [7:0] b, input logic nack);
		xf({b, 1'b1}, {b, nack});
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (write_busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		`CHK(n < 300, 1'b1)
	endtask

	task automatic wframe(input logic [10:0] a, input int n);
		logic [7:0] d;
		ctl.start();
		wb({4'hA, a[10:8], 1'b0}, 1'b0);
		wb(a[7:0], 1'b0);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			wb(d, 1'b0);
			if (!wp) mem[{a[10:4], a[3:0] + i[3:0]}] = d;
		end
		ctl.stop();
		repeat (6) @(posedge clk);
		`CHK(write_busy, ~wp)
		ctl.start();
		wb({4'hA, a[10:8], 1'b0}, write_busy);
		wait_idle();
		ctl.start();
		wb({4'hA, a[10:8], 1'b0}, 1'b0);
		ctl.stop();
	endtask

	task automatic rframe(input logic [10:0] a, input int n,
		input logic dummy);
		logic [10:0] p;
		p = a;
		if (dummy) begin
			ctl.start();
			wb({4'hA, a[10:8], 1'b0}, 1'b0);
			wb(a[7:0], 1'b0);
		end
		ctl.start();
		wb({4'hA, a[10:8], 1'b1}, 1'b0);
		for (int i = 0; i < n; i++) begin
			xf({8'hFF, i == n - 1}, {mem[p], i == n - 1});
			p = p + 11'd1;
		end
		ctl.stop();
	endtask

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		ctl.pulses(4);
		// sda edges under reset clear both condition detectors
		ctl.start();
		ctl.stop();
		@(posedge clk);
		srst <= 1'b0;
		ctl.pulses(4);
		`CHK(sda_oe, 1'b0)
		`CHK(sda_out, 1'b0)
		`CHK(write_busy, 1'b0)
		wframe(11'h5F8, 17);
		wframe(11'h000, 2);
		wframe(11'h7FF, 1);
		// abort inside a data byte, then bus recovery
		ctl.start();
		wb(8'hA0, 1'b0);
		wb(8'h00, 1'b0);
		wb(8'h5A, 1'b0);
		ctl.pulses(3);
		ctl.stop();
		repeat (6) @(posedge clk);
		`CHK(write_busy, 1'b0)
		ctl.start();
		ctl.pulses(9);
		ctl.start();
		ctl.stop();
		ctl.start();
		wb(8'hA0, 1'b0);
		// foreign address, then a stray byte without start
		ctl.start();
		wb(8'hB0, 1'b1);
		wb(8'hA0, 1'b1);
		ctl.stop();
		@(posedge clk);
		wp <= 1'b1;
		repeat (3) @(posedge clk);
		wframe(11'h001, 1);
		rframe(11'h5F0, 16, 1'b1);
		rframe(11'h7FF, 2, 1'b1);
		rframe(11'h001, 1, 1'b0);
		repeat (10) @(posedge clk);
		`CHK(exp_q.size(), 0)
		conclude();
	end

	initial begin
		#200000;
		miscompares++;
		$display("ERROR %0t: watchdog expired", $time);
		conclude();
	end

endmodule
